// ==== design/strap_pkg.sv ====
package strap_pkg;
    // i/o port pair of the indexed configuration space
    localparam logic [15:0] INDEX_PORT = 16'h0022;
    localparam logic [15:0] DATA_PORT = 16'h0023;
    // register indices
    localparam logic [7:0] STRAP_CONFIG_0_IDX = 8'h4a;
    localparam logic [7:0] STRAP_CONFIG_2_IDX = 8'h4c;
    // strap_config_0 field positions
    localparam int PCI_PLL_HI = 7;
    localparam int PCI_PLL_LO = 6;
    localparam int SYNC_BIT = 5;
    localparam int DIV_BIT = 4;
    // strap_config_2 field position of the second divisor strap
    localparam int DIV2_BIT = 1;
    // pin positions in the memory data bus
    localparam int DIV2_PIN = 17;
    localparam int MULT_PIN = 40;
    localparam int PIN_WIDTH = 41;
    // pci pll range encodings
    localparam logic [1:0] PLL_16_32 = 2'b00;
    localparam logic [1:0] PLL_32_64 = 2'b01;
    // pci clock divisors
    localparam logic [2:0] DIV_BY_4 = 3'h4;
    localparam logic [2:0] DIV_BY_3 = 3'h3;
    localparam logic [2:0] DIV_BY_2 = 3'h2;
    // read value returned for an index that holds no register
    localparam logic [7:0] UNMAPPED_DATA = 8'hff;
endpackage

// ==== design/strap_cfg_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// carries the decoded clock setup from the strap store to the top
interface strap_cfg_if;
    logic [1:0] pll_range;
    logic sync_mode;
    logic [2:0] pci_div;
    logic mult_x2;
    logic reserved_pll;
    modport source (output pll_range, sync_mode, pci_div, mult_x2, reserved_pll);
    modport sink (input pll_range, sync_mode, pci_div, mult_x2, reserved_pll);
endinterface
`default_nettype wire

// ==== design/strap_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// clock setup decode from the held strap registers
module strap_decode
    import strap_pkg::*;
(
    input wire logic [7:0] cfg0,
    input wire logic div2_strap,
    input wire logic mult_strap,
    strap_cfg_if.source cfg
);
    // divisor choice: first strap low gives 4, else second strap picks
    function automatic logic [2:0] pick_div(input logic s1, input logic s2);
        if (!s1)
            pick_div = DIV_BY_4;
        else if (!s2)
            pick_div = DIV_BY_3;
        else
            pick_div = DIV_BY_2;
    endfunction

    // all outputs are pure functions of the held straps
    always_comb
    begin
        cfg.pll_range = cfg0[PCI_PLL_HI:PCI_PLL_LO];
        cfg.reserved_pll = cfg0[PCI_PLL_HI];
        cfg.sync_mode = cfg0[SYNC_BIT];
        cfg.pci_div = pick_div(cfg0[DIV_BIT], div2_strap);
        cfg.mult_x2 = mult_strap;
    end
endmodule
`default_nettype wire

// ==== design/power_on_strap_config.sv ====
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// strap capture, indexed register read port and clock setup outputs
module power_on_strap_config
    import strap_pkg::*;
#(
    parameter int PINS = PIN_WIDTH
)
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [PINS-1:0] memory_data_strap_pins,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic [1:0] pci_pll_range,
    output logic pll_range_reserved,
    output logic sync_mode,
    output logic [2:0] pci_clock_output_div,
    output logic core_mult_x2
);
    // =================================================================
    // strap capture state
    logic captured_reg;
    logic captured_next;
    logic [7:0] strap_config_0_reg;
    logic [7:0] strap_config_0_next;
    logic div2_reg;
    logic div2_next;
    logic mult_reg;
    logic mult_next;

    // capture on the first clock after release; a flop under async reset
    // may only take a constant, so the pins are sampled by the clock
    always_comb
    begin
        captured_next = 1'b1;
        strap_config_0_next = strap_config_0_reg;
        div2_next = div2_reg;
        mult_next = mult_reg;
        if (!captured_reg)
        begin
            strap_config_0_next = memory_data_strap_pins[7:0];
            div2_next = memory_data_strap_pins[DIV2_PIN];
            mult_next = memory_data_strap_pins[MULT_PIN];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            captured_reg <= 1'b0;
            strap_config_0_reg <= 8'h00;
            div2_reg <= 1'b0;
            mult_reg <= 1'b0;
        end
        else
        begin
            captured_reg <= captured_next;
            strap_config_0_reg <= strap_config_0_next;
            div2_reg <= div2_next;
            mult_reg <= mult_next;
        end
    end

    // =================================================================
    // index/data port pair
    logic [7:0] index_reg;
    logic [7:0] index_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // writes to the data port are dropped: the straps are read-only
    always_comb
    begin
        index_next = index_reg;
        rdata_next = rdata_reg;
        if (io_wr && io_addr == INDEX_PORT)
            index_next = io_wdata;
        if (io_rd && io_addr == DATA_PORT)
        begin
            if (index_reg == STRAP_CONFIG_0_IDX)
                rdata_next = strap_config_0_reg;
            else if (index_reg == STRAP_CONFIG_2_IDX)
                rdata_next = {6'h00, div2_reg, 1'b0};
            else
                rdata_next = UNMAPPED_DATA;
        end
        else if (io_rd && io_addr == INDEX_PORT)
            rdata_next = index_reg;
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            index_reg <= 8'h00;
            rdata_reg <= 8'h00;
        end
        else
        begin
            index_reg <= index_next;
            rdata_reg <= rdata_next;
        end
    end

    assign io_rdata = rdata_reg;

    // =================================================================
    // decode and register the clock setup outputs
    strap_cfg_if cfg_bus ();

    strap_decode u_decode (
        .cfg0(strap_config_0_reg),
        .div2_strap(div2_reg),
        .mult_strap(mult_reg),
        .cfg(cfg_bus.source)
    );

    logic [1:0] pll_reg;
    logic pll_res_reg;
    logic sync_reg;
    logic [2:0] div_reg;
    logic x2_reg;

    // outputs registered so each comes from a flop; they settle two
    // cycles after release, one after the capture
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pll_reg <= PLL_16_32;
            pll_res_reg <= 1'b0;
            sync_reg <= 1'b0;
            div_reg <= DIV_BY_4;
            x2_reg <= 1'b0;
        end
        else
        begin
            pll_reg <= cfg_bus.pll_range;
            pll_res_reg <= cfg_bus.reserved_pll;
            sync_reg <= cfg_bus.sync_mode;
            div_reg <= cfg_bus.pci_div;
            x2_reg <= cfg_bus.mult_x2;
        end
    end

    assign pci_pll_range = pll_reg;
    assign pll_range_reserved = pll_res_reg;
    assign sync_mode = sync_reg;
    assign pci_clock_output_div = div_reg;
    assign core_mult_x2 = x2_reg;

    // =================================================================
    // checks
    sequence s_captured;
        captured_reg && !$past(captured_reg);
    endsequence

    property p_load;
        @(posedge sys_clk) disable iff (!arst_n)
        s_captured |-> strap_config_0_reg == $past(memory_data_strap_pins[7:0]);
    endproperty
    a_load: assert property (p_load) else $error("strap load wrong");

    property p_hold;
        @(posedge sys_clk) disable iff (!arst_n)
        $past(captured_reg) |-> $stable(strap_config_0_reg) && $stable(mult_reg)
            && $stable(div2_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("strap changed");

    property p_read;
        @(posedge sys_clk) disable iff (!arst_n)
        io_rd && io_addr == DATA_PORT && index_reg == STRAP_CONFIG_0_IDX
            |=> io_rdata == $past(strap_config_0_reg);
    endproperty
    a_read: assert property (p_read) else $error("read wrong");

    property p_div;
        @(posedge sys_clk) disable iff (!arst_n)
        captured_reg |=> pci_clock_output_div ==
            (!$past(strap_config_0_reg[DIV_BIT]) ? DIV_BY_4 :
             ($past(div2_reg) ? DIV_BY_2 : DIV_BY_3));
    endproperty
    a_div: assert property (p_div) else $error("divisor wrong");

    property p_sync;
        @(posedge sys_clk) disable iff (!arst_n)
        captured_reg |=> sync_mode == $past(strap_config_0_reg[SYNC_BIT]);
    endproperty
    a_sync: assert property (p_sync) else $error("sync wrong");

    property p_mult;
        @(posedge sys_clk) disable iff (!arst_n)
        s_captured ##1 1'b1 |-> core_mult_x2 == $past(memory_data_strap_pins[MULT_PIN], 2);
    endproperty
    a_mult: assert property (p_mult) else $error("multiplier wrong");

    property p_pll;
        @(posedge sys_clk) disable iff (!arst_n)
        captured_reg |=> pll_range_reserved == $past(strap_config_0_reg[PCI_PLL_HI])
            && pci_pll_range == $past(strap_config_0_reg[PCI_PLL_HI:PCI_PLL_LO]);
    endproperty
    a_pll: assert property (p_pll) else $error("pll reserved flag wrong");

    property p_index;
        @(posedge sys_clk) disable iff (!arst_n)
        io_wr && io_addr == INDEX_PORT |=> index_reg == $past(io_wdata);
    endproperty
    a_index: assert property (p_index) else $error("index not taken");
endmodule
`default_nettype wire

// ==== sim/strap_network.sv ====
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// board strap resistors: user-defined pins follow the bench's choice,
// reserved pins sit at their pull level; md7 is a pull-down unless a
// scenario deliberately straps it high to reach the reserved pll pattern
module strap_network
    import strap_pkg::*;
#(
    parameter int PINS = PIN_WIDTH
)
(
    input wire logic [PINS-1:0] user_pins,
    input wire logic bad_md7,
    output logic [PINS-1:0] pins
);
    localparam logic [PINS-1:0] USER_MASK = 41'h100_0702_007f;
    localparam logic [PINS-1:0] PULL_UPS = 41'h000_00fd_0000;
    // resistors never float, so every pin has a defined level
    always_comb
    begin
        pins = (user_pins & USER_MASK) | (PULL_UPS & ~USER_MASK);
        pins[7] = bad_md7;
    end
endmodule
`default_nettype wire

// ==== sim/power_on_strap_config_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module power_on_strap_config_tb;
    import strap_pkg::*;
    logic sys_clk, arst_n, io_wr, io_rd, bad_md7, mult_x2;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, got, clk_exp;
    logic [1:0] pci_pll_range;
    logic pll_range_reserved, sync_mode;
    logic [2:0] pci_clock_output_div;
    logic [40:0] user_pins, pins, up;
    logic [9:0] tbl [4] = '{10'h000, 10'h1c1, 10'h27e, 10'h0b2};
    int err_count = 0;
    int checks = 0;
    // =================================================================
    // clock, partner and design
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    strap_network net_u (.user_pins(user_pins), .bad_md7(bad_md7), .pins(pins));
    power_on_strap_config dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
        .memory_data_strap_pins(pins), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .pci_pll_range(pci_pll_range),
        .pll_range_reserved(pll_range_reserved), .sync_mode(sync_mode),
        .pci_clock_output_div(pci_clock_output_div), .core_mult_x2(mult_x2));
    // =================================================================
    // access tasks
    task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, g, e);
        end
    endtask
    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        io_wr <= 1'b1;
        io_addr <= a;
        io_wdata <= d;
        @(posedge sys_clk);
        io_wr <= 1'b0;
    endtask
    // answer lands at the edge taking the strobe, so sample just after it
    task automatic io_read(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        io_rd <= 1'b1;
        io_addr <= a;
        @(posedge sys_clk);
        io_rd <= 1'b0;
        #1 d = io_rdata;
    endtask
    task automatic reg_read(input logic [7:0] idx, output logic [7:0] d);
        io_write(INDEX_PORT, idx);
        io_read(DATA_PORT, d);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // =================================================================
    // tests: each strap set goes through a full reset and readback
    initial
    begin
        arst_n = 1'b0;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = 16'h0000;
        io_wdata = 8'h00;
        bad_md7 = 1'b0;
        user_pins = '0;
        repeat (20) @(posedge sys_clk);
        // the release lands after this edge, so the outputs still show reset values
        arst_n <= 1'b1;
        #1 check({pci_pll_range, pll_range_reserved, sync_mode, pci_clock_output_div, mult_x2},
            {4'h0, DIV_BY_4, 1'b0}, "reset outputs");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge sys_clk);
            arst_n <= 1'b0;
            up = '0;
            up[6:0] = tbl[i][8:2];
            up[DIV2_PIN] = tbl[i][1];
            up[MULT_PIN] = tbl[i][0];
            user_pins <= up;
            bad_md7 <= tbl[i][9];
            repeat (3) @(posedge sys_clk);
            arst_n <= 1'b1;
            repeat (3) @(posedge sys_clk);
            reg_read(STRAP_CONFIG_0_IDX, got);
            check(got, tbl[i][9:2], "strap_config_0");
            clk_exp = {tbl[i][9], tbl[i][8], tbl[i][9], tbl[i][7],
                tbl[i][6] ? (tbl[i][1] ? DIV_BY_2 : DIV_BY_3) : DIV_BY_4, tbl[i][0]};
            // later pin changes must not reach the held straps
            @(posedge sys_clk);
            user_pins <= ~up;
            bad_md7 <= ~tbl[i][9];
            repeat (2) @(posedge sys_clk);
            #1 check({pci_pll_range, pll_range_reserved, sync_mode, pci_clock_output_div,
                mult_x2}, clk_exp, "clock setup");
            reg_read(STRAP_CONFIG_0_IDX, got);
            check(got, tbl[i][9:2], "held strap_config_0");
            reg_read(STRAP_CONFIG_2_IDX, got);
            check(got, {6'h00, tbl[i][1], 1'b0}, "second divisor strap");
        end
        // strap register is read-only: a data port write leaves it alone
        io_write(INDEX_PORT, STRAP_CONFIG_0_IDX);
        io_write(DATA_PORT, 8'h55);
        io_read(DATA_PORT, got);
        check(got, tbl[3][9:2], "write ignored");
        io_read(INDEX_PORT, got);
        check(got, STRAP_CONFIG_0_IDX, "index readback");
        reg_read(8'h4b, got);
        check(got, UNMAPPED_DATA, "unmapped index");
        print_verdict();
    end
    // watchdog: the tests need about 120 cycles
    initial
    begin
        #200000;
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule
`default_nettype wire
